// ===== shared/flash_host_pkg.sv
// constants and types shared by the flash mode/protection host controller
// assumes a 10 MHz system clock and a parallel flash with word addressing
package flash_host_pkg;

    // --------------------------------------------------------------
    // widths and clock
    // --------------------------------------------------------------
    localparam int ADDR_W        = 19;
    localparam int DATA_W        = 16;
    localparam int CLK_PERIOD_NS = 100;
    localparam int SYNC_STAGES   = 2;

    // --------------------------------------------------------------
    // timing, in printed units, and derived cycle counts
    // --------------------------------------------------------------
    localparam int T_ACCESS_NS   = 150;
    localparam int T_WRPULSE_NS  = 100;
    localparam int T_GLITCH_NS   = 5;
    localparam int ACC_CYC       = (T_ACCESS_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
    localparam int WP_RAW        = (T_WRPULSE_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
    localparam int GL_RAW        = T_GLITCH_NS / CLK_PERIOD_NS + 1;
    // a strobe must outlast the glitch filter as well as the pulse spec
    localparam int WP_CYC        = (WP_RAW > GL_RAW) ? WP_RAW : GL_RAW;
    localparam int RD_CYC        = ACC_CYC + SYNC_STAGES;
    localparam int CNT_W         = 4;

    // --------------------------------------------------------------
    // command values and addresses
    // --------------------------------------------------------------
    localparam logic [7:0]        CMD_UNLOCK1   = 8'haa;
    localparam logic [7:0]        CMD_UNLOCK2   = 8'h55;
    localparam logic [7:0]        CMD_IDENT     = 8'h90;
    localparam logic [7:0]        CMD_RESET     = 8'hf0;
    localparam logic [ADDR_W-1:0] ADR_UNLOCK1   = 19'h00555;
    localparam logic [ADDR_W-1:0] ADR_UNLOCK2   = 19'h002aa;
    localparam logic [ADDR_W-1:0] ADR_PROT_OFS  = 19'h00002;
    localparam logic [ADDR_W-1:0] ADR_SECT_MASK = 19'h7f000;
    localparam int                SECT_LSB      = 12;
    localparam int                SECT_STEPS_W  = 7;
    localparam int                TIMEOUT_BIT   = 5;
    localparam logic [7:0]        PROT_NONE     = 8'h00;

    // --------------------------------------------------------------
    // user operations
    // --------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_READ       = 4'h0,
        OP_WRITE      = 4'h1,
        OP_RESET      = 4'h2,
        OP_ID_CMD     = 4'h3,
        OP_ID_HV      = 4'h4,
        OP_PROT_CHECK = 4'h5,
        OP_POLL       = 4'h6,
        OP_TEMP_UNPROT= 4'h7,
        OP_UNPROT_PREP= 4'h8
    } op_type;

    typedef struct packed {
        logic              act;
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        data;
        logic              last;
    } step_type;

endpackage : flash_host_pkg

// ===== shared/bus_cycle_if.sv
// carries one flash bus cycle request between sequencer and pin engine
// assumes both ends run on the same clock
`timescale 1ns/10ps
interface bus_cycle_if;
    import flash_host_pkg::*;
    logic              req;
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              done;
    logic [DATA_W-1:0] rdata;

    modport seq (output req, output we, output addr, output wdata,
                 input done, input rdata);
    modport eng (input req, input we, input addr, input wdata,
                 output done, output rdata);
endinterface : bus_cycle_if

// ===== hw/flash_pin_engine.sv
// drives one read or write cycle on the flash control, address, data pins
// assumes the pin inputs are asynchronous and the clock is 10 MHz
`timescale 1ns/10ps
module flash_pin_engine
    import flash_host_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              resetn_i,
    bus_cycle_if.eng               bus,
    input  wire logic [DATA_W-1:0] dq_i,
    output logic      [DATA_W-1:0] dq_o,
    output logic                   dq_oe_o,
    output logic      [ADDR_W-1:0] addr_o,
    output logic                   ce_n_o,
    output logic                   oe_n_o,
    output logic                   we_n_o
);

    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    typedef enum logic [2:0] {
        E_IDLE   = 3'b000,
        E_SETUP  = 3'b001,
        E_STROBE = 3'b011,
        E_END    = 3'b010
    } eng_state_type;

    eng_state_type     state_ff;
    logic [CNT_W-1:0]  cnt_ff;
    logic              we_ff;
    logic [DATA_W-1:0] sync1_ff;
    logic [DATA_W-1:0] sync2_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic              done_ff;

    wire logic [CNT_W-1:0] strobe_len = we_ff ? CNT_W'(WP_CYC)
                                              : CNT_W'(RD_CYC);
    wire logic             strobe_end = (cnt_ff == strobe_len - 1'b1);

    assign bus.done  = done_ff;
    assign bus.rdata = rdata_ff;

    // --------------------------------------------------------------
    // data pin synchroniser
    // --------------------------------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else begin
            sync1_ff <= dq_i;
            sync2_ff <= sync1_ff;
        end
    end

    // --------------------------------------------------------------
    // cycle sequencing
    // --------------------------------------------------------------
    // strobes idle high from reset so no write is seen at power-up
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_ff <= E_IDLE;
            cnt_ff   <= '0;
            we_ff    <= 1'b0;
            done_ff  <= 1'b0;
            rdata_ff <= '0;
            addr_o   <= '0;
            dq_o     <= '0;
            dq_oe_o  <= 1'b0;
            ce_n_o   <= 1'b1;
            oe_n_o   <= 1'b1;
            we_n_o   <= 1'b1;
        end else begin
            done_ff <= 1'b0;
            case (state_ff)
                E_IDLE: begin
                    if (bus.req) begin
                        // address settles before the later falling edge
                        addr_o   <= bus.addr;
                        dq_o     <= bus.wdata;
                        dq_oe_o  <= bus.we;
                        we_ff    <= bus.we;
                        state_ff <= E_SETUP;
                    end
                end
                E_SETUP: begin
                    cnt_ff   <= '0;
                    ce_n_o   <= 1'b0;
                    // write only with ce and we low and oe high
                    we_n_o   <= !we_ff;
                    oe_n_o   <= we_ff;
                    state_ff <= E_STROBE;
                end
                E_STROBE: begin
                    cnt_ff <= cnt_ff + 1'b1;
                    if (strobe_end) begin
                        if (!we_ff) begin
                            rdata_ff <= sync2_ff;
                        end
                        ce_n_o   <= 1'b1;
                        we_n_o   <= 1'b1;
                        oe_n_o   <= 1'b1;
                        state_ff <= E_END;
                    end
                end
                E_END: begin
                    // data held past the earlier rising edge
                    dq_oe_o  <= 1'b0;
                    done_ff  <= 1'b1;
                    state_ff <= E_IDLE;
                end
                default: begin
                    state_ff <= E_IDLE;
                end
            endcase
        end
    end

endmodule : flash_pin_engine

// ===== hw/flash_mode_protect_host.sv
// host controller for identifier readout and sector protection control
// assumes a 10 MHz clock and a flash wired to the pin ports below
//
// What this block does
// - ident by equipment holds high voltage on the id select line
// - protect check puts sector number high; 00h means unprotected
// - protect/unprotect needs high voltage on the clear pin, bus writes
// - protect all unprotected sectors before the first unprotect write; the block withholds unprot_permit_o until a survey finds no sector reading 00h
// - a write needs chip select and write strobe low, output enable high
// - write reset after timeout error bit high or ident readout
`timescale 1ns/10ps
module flash_mode_protect_host
    import flash_host_pkg::*;
#(
    parameter int SECT_STEPS = 128
)(
    input  wire logic              clk_i,
    input  wire logic              resetn_i,
    // user command port
    input  wire logic              cmd_valid_i,
    output logic                   cmd_ready_o,
    input  wire logic [3:0]        cmd_op_i,
    input  wire logic [ADDR_W-1:0] cmd_addr_i,
    input  wire logic [DATA_W-1:0] cmd_data_i,
    output logic                   rsp_valid_o,
    output logic      [DATA_W-1:0] rsp_data_o,
    output logic                   rsp_err_o,
    output logic                   unprot_permit_o,
    input  wire logic              supply_lockout_level_i,
    // flash pins
    input  wire logic [DATA_W-1:0] dq_i,
    output logic      [DATA_W-1:0] dq_o,
    output logic                   dq_oe_o,
    output logic      [ADDR_W-1:0] addr_o,
    output logic                   ce_n_o,
    output logic                   oe_n_o,
    output logic                   we_n_o,
    output logic                   id_select_hv_o,
    output logic                   clear_pin_hv_o
);

    // --------------------------------------------------------------
    // sequencer state
    // --------------------------------------------------------------
    typedef enum logic [1:0] {
        S_IDLE  = 2'b00,
        S_ISSUE = 2'b01,
        S_WAIT  = 2'b11,
        S_DONE  = 2'b10
    } seq_state_type;

    seq_state_type          state_ff;
    op_type                 op_ff;
    logic [ADDR_W-1:0]      addr_ff;
    logic [DATA_W-1:0]      data_ff;
    logic [2:0]             step_ff;
    logic [SECT_STEPS_W-1:0] sect_ff;
    logic                   err_ff;
    logic                   lock1_ff;
    logic                   lock2_ff;
    logic                   req_ff;
    logic                   hv_id_ff;
    logic                   hv_clr_ff;
    logic                   permit_ff;
    logic                   rsp_valid_ff;
    logic [DATA_W-1:0]      rsp_data_ff;
    logic                   tmo_reset_ff;

    bus_cycle_if bus ();

    flash_pin_engine u_engine (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .bus      (bus),
        .dq_i     (dq_i),
        .dq_o     (dq_o),
        .dq_oe_o  (dq_oe_o),
        .addr_o   (addr_o),
        .ce_n_o   (ce_n_o),
        .oe_n_o   (oe_n_o),
        .we_n_o   (we_n_o)
    );

    // --------------------------------------------------------------
    // sequence table
    // --------------------------------------------------------------
    function automatic step_type mk(input logic we,
                                    input logic [ADDR_W-1:0] a,
                                    input logic [7:0] d,
                                    input logic last);
        step_type s;
        s.act  = 1'b1;
        s.we   = we;
        s.addr = a;
        s.data = d;
        s.last = last;
        return s;
    endfunction : mk

    function automatic step_type seq_step(input op_type op,
                                          input logic [2:0] n,
                                          input logic [ADDR_W-1:0] a,
                                          input logic [7:0] d,
                                          input logic tmo);
        step_type s;
        s = '0;
        case (op)
            OP_READ:  s = mk(1'b0, a, 8'h00, 1'b1);
            OP_WRITE: s = mk(1'b1, a, d, 1'b1);
            // address is a don't-care for reset, so none is decoded
            OP_RESET: s = mk(1'b1, '0, CMD_RESET, 1'b1);
            OP_POLL: begin
                if (n == 3'd0) begin
                    s = mk(1'b0, a, 8'h00, 1'b0);
                end else begin
                    // timeout error bit seen: back to array read
                    s = mk(1'b1, '0, CMD_RESET, 1'b1);
                    s.act = tmo;
                end
            end
            OP_ID_CMD, OP_PROT_CHECK: begin
                case (n)
                    3'd0: s = mk(1'b1, ADR_UNLOCK1, CMD_UNLOCK1, 1'b0);
                    3'd1: s = mk(1'b1, ADR_UNLOCK2, CMD_UNLOCK2, 1'b0);
                    3'd2: s = mk(1'b1, ADR_UNLOCK1, CMD_IDENT, 1'b0);
                    3'd3: s = mk(1'b0, (op == OP_PROT_CHECK) ?
                                 ((a & ADR_SECT_MASK) | ADR_PROT_OFS) : a,
                                 8'h00, 1'b0);
                    default: s = mk(1'b1, '0, CMD_RESET, 1'b1);
                endcase
            end
            OP_ID_HV: s = mk(1'b0, a, 8'h00, 1'b1);
            default: s = '0;
        endcase
        return s;
    endfunction : seq_step

    wire step_type cur = seq_step(op_ff, step_ff, addr_ff,
                                  data_ff[7:0], tmo_reset_ff);

    // sector walk address for the pre-unprotect protection survey
    wire logic [ADDR_W-1:0] sect_addr =
        (ADDR_W'(sect_ff) << SECT_LSB) | ADR_PROT_OFS;
    wire logic sect_last = (sect_ff == SECT_STEPS_W'(SECT_STEPS - 1));
    wire logic is_write_op = (cmd_op_i == OP_WRITE) ||
                             (cmd_op_i == OP_RESET) ||
                             (cmd_op_i == OP_ID_CMD) ||
                             (cmd_op_i == OP_PROT_CHECK) ||
                             (cmd_op_i == OP_POLL);
    wire logic is_walk = (op_ff == OP_UNPROT_PREP);
    wire logic rd_tmo  = bus.rdata[TIMEOUT_BIT];

    assign cmd_ready_o     = (state_ff == S_IDLE);
    assign rsp_valid_o     = rsp_valid_ff;
    assign rsp_data_o      = rsp_data_ff;
    assign rsp_err_o       = err_ff;
    assign unprot_permit_o = permit_ff;
    assign id_select_hv_o  = hv_id_ff;
    assign clear_pin_hv_o  = hv_clr_ff;
    assign bus.req         = req_ff;
    assign bus.we          = is_walk ? 1'b0 : cur.we;
    assign bus.addr        = is_walk ? sect_addr : cur.addr;
    assign bus.wdata       = DATA_W'(cur.data);

    // --------------------------------------------------------------
    // lockout flag synchroniser
    // --------------------------------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            lock1_ff <= 1'b1;
            lock2_ff <= 1'b1;
        end else begin
            lock1_ff <= supply_lockout_level_i;
            lock2_ff <= lock1_ff;
        end
    end

    // --------------------------------------------------------------
    // sequencer
    // --------------------------------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_ff     <= S_IDLE;
            op_ff        <= OP_READ;
            addr_ff      <= '0;
            data_ff      <= '0;
            step_ff      <= '0;
            sect_ff      <= '0;
            err_ff       <= 1'b0;
            req_ff       <= 1'b0;
            hv_id_ff     <= 1'b0;
            hv_clr_ff    <= 1'b0;
            permit_ff    <= 1'b0;
            rsp_valid_ff <= 1'b0;
            rsp_data_ff  <= '0;
            tmo_reset_ff <= 1'b0;
        end else begin
            rsp_valid_ff <= 1'b0;
            req_ff       <= 1'b0;
            case (state_ff)
                S_IDLE: begin
                    if (cmd_valid_i) begin
                        op_ff        <= op_type'(cmd_op_i);
                        addr_ff      <= cmd_addr_i;
                        data_ff      <= cmd_data_i;
                        step_ff      <= '0;
                        sect_ff      <= '0;
                        err_ff       <= 1'b0;
                        tmo_reset_ff <= 1'b0;
                        state_ff     <= S_ISSUE;
                        if (is_write_op && lock2_ff) begin
                            // no write cycles while supply is low
                            err_ff   <= 1'b1;
                            state_ff <= S_DONE;
                        end else if (cmd_op_i == OP_TEMP_UNPROT) begin
                            hv_clr_ff <= cmd_data_i[0];
                            state_ff  <= S_DONE;
                        end else if (cmd_op_i == OP_ID_HV ||
                                     cmd_op_i == OP_UNPROT_PREP) begin
                            hv_id_ff  <= 1'b1;
                            permit_ff <= 1'b0;
                        end
                    end
                end
                S_ISSUE: begin
                    if (cur.act || is_walk) begin
                        req_ff   <= 1'b1;
                        state_ff <= S_WAIT;
                    end else begin
                        state_ff <= S_DONE;
                    end
                end
                S_WAIT: begin
                    if (bus.done) begin
                        state_ff <= S_ISSUE;
                        if (is_walk) begin
                            // an unprotected sector blocks unprotect
                            if (bus.rdata[7:0] == PROT_NONE) begin
                                err_ff <= 1'b1;
                            end
                            sect_ff <= sect_ff + 1'b1;
                            if (sect_last) begin
                                state_ff <= S_DONE;
                            end
                        end else begin
                            if (!cur.we) begin
                                rsp_data_ff  <= bus.rdata;
                                tmo_reset_ff <= rd_tmo;
                            end
                            step_ff <= step_ff + 1'b1;
                            if (cur.last) begin
                                state_ff <= S_DONE;
                            end
                        end
                    end
                end
                S_DONE: begin
                    hv_id_ff     <= 1'b0;
                    rsp_valid_ff <= 1'b1;
                    if (is_walk) begin
                        permit_ff <= !err_ff;
                    end
                    state_ff <= S_IDLE;
                end
                default: begin
                    state_ff <= S_IDLE;
                end
            endcase
        end
    end

endmodule : flash_mode_protect_host

// ===== sim/flash_mode_protect_host_asserts.sv
// pin and answer checks for the flash mode and protection host controller
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/10ps
module flash_mode_protect_host_asserts
    import flash_host_pkg::*;
#(
    parameter int SECT_STEPS = 128
)(
    input wire logic              clk_i,
    input wire logic              resetn_i,
    input wire logic              cmd_valid_i,
    input wire logic              cmd_ready_o,
    input wire logic [3:0]        cmd_op_i,
    input wire logic [DATA_W-1:0] cmd_data_i,
    input wire logic              rsp_valid_o,
    input wire logic              rsp_err_o,
    input wire logic              supply_lockout_level_i,
    input wire logic [DATA_W-1:0] dq_o,
    input wire logic              dq_oe_o,
    input wire logic [ADDR_W-1:0] addr_o,
    input wire logic              ce_n_o,
    input wire logic              oe_n_o,
    input wire logic              we_n_o,
    input wire logic              id_select_hv_o,
    input wire logic              clear_pin_hv_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    wire take    = cmd_valid_i && cmd_ready_o;
    wire take_wr = take && (cmd_op_i inside {OP_WRITE, OP_RESET,
                   OP_ID_CMD, OP_PROT_CHECK, OP_POLL});
    // lockout must have crossed both sync stages before the take
    sequence lock_held;
        supply_lockout_level_i [*4];
    endsequence
    sequence refused;
        ##1 we_n_o ##1 (we_n_o && rsp_valid_o && rsp_err_o);
    endsequence
    chk_write_gate: assert property (!we_n_o |-> !ce_n_o && oe_n_o)
        else $error("bad write controls");
    chk_read_gate: assert property (!oe_n_o |->
        !ce_n_o && we_n_o && !dq_oe_o)
        else $error("bad read controls");
    chk_addr_setup: assert property ($fell(ce_n_o) |-> $stable(addr_o))
        else $error("address changed as select fell");
    chk_addr_hold: assert property (!ce_n_o && $past(!ce_n_o) |->
        $stable(addr_o))
        else $error("address changed during a bus cycle");
    chk_data_hold: assert property ($rose(we_n_o) |->
        dq_oe_o && $stable(dq_o))
        else $error("write data not held at strobe rise");
    chk_hv_read_only: assert property (id_select_hv_o |-> we_n_o)
        else $error("write under id high voltage");
    chk_op_answer: assert property (take && cmd_op_i != OP_UNPROT_PREP
        |=> !cmd_ready_o ##[0:600] rsp_valid_o)
        else $error("operation not answered in time");
    chk_lock_refuse: assert property (lock_held ##0 take_wr |-> refused)
        else $error("write operation not refused under lockout");
    chk_temp_level: assert property (take &&
        cmd_op_i == OP_TEMP_UNPROT |-> ##2 (rsp_valid_o &&
        clear_pin_hv_o == $past(cmd_data_i[0], 2)))
        else $error("clear pin level wrong");
endmodule : flash_mode_protect_host_asserts

bind flash_mode_protect_host flash_mode_protect_host_asserts #(
    .SECT_STEPS(SECT_STEPS)
) u_chk (
    .clk_i(clk_i), .resetn_i(resetn_i), .cmd_valid_i(cmd_valid_i),
    .cmd_ready_o(cmd_ready_o), .cmd_op_i(cmd_op_i), .cmd_data_i(cmd_data_i),
    .rsp_valid_o(rsp_valid_o), .rsp_err_o(rsp_err_o),
    .supply_lockout_level_i(supply_lockout_level_i), .dq_o(dq_o),
    .dq_oe_o(dq_oe_o), .addr_o(addr_o), .ce_n_o(ce_n_o), .oe_n_o(oe_n_o),
    .we_n_o(we_n_o), .id_select_hv_o(id_select_hv_o),
    .clear_pin_hv_o(clear_pin_hv_o)
);

// ===== sim/flash_dev_model.sv
// behavioural flash: array reads, unlock decode, identifier readout
// assumes host pin levels and a sector protection map from the bench
`timescale 1ns/10ps
module flash_dev_model
    import flash_host_pkg::*;
#(
    parameter logic [7:0] MFR = 8'h3c, // arbitrary value
    parameter logic [7:0] DEV = 8'h5e  // arbitrary value
)(
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] dq_i,
    input  wire logic              ce_n_i,
    input  wire logic              oe_n_i,
    input  wire logic              we_n_i,
    input  wire logic              id_hv_i,
    input  wire logic [127:0]      prot_i,
    output logic      [DATA_W-1:0] dq_o
);
    logic [ADDR_W-1:0] lat_a;
    logic [1:0]        step = 2'h0;
    logic              ident = 1'b0;
    logic [DATA_W-1:0] last = 16'h0000;
    wire               wr = !ce_n_i && !we_n_i && oe_n_i;
    wire               rd = !ce_n_i && !oe_n_i;
    wire [7:0]         code = (addr_i[1:0] == 2'h0) ? MFR :
                              (addr_i[1:0] == 2'h1) ? DEV :
                              {7'h00, prot_i[addr_i[18:12]]};
    always @(posedge wr) lat_a = addr_i;
    always @(negedge wr) begin
        if (dq_i[7:0] == CMD_RESET) begin
            step = 2'h0;
            ident = 1'b0;
        end else if (step == 2'h0 && lat_a == ADR_UNLOCK1 &&
            dq_i[7:0] == CMD_UNLOCK1)
            step = 2'h1;
        else if (step == 2'h1 && lat_a == ADR_UNLOCK2 &&
            dq_i[7:0] == CMD_UNLOCK2)
            step = 2'h2;
        else if (step == 2'h2 && lat_a == ADR_UNLOCK1 &&
            dq_i[7:0] == CMD_IDENT) begin
            step = 2'h0;
            ident = 1'b1;
        end else
            step = 2'h0;
    end
    // released bus shows the inverse so a stale sample cannot pass
    always @(rd, addr_i, ident, id_hv_i, prot_i, code) begin
        if (rd && (ident || id_hv_i)) last = {8'h00, code};
        else if (rd) last = addr_i[15:0] ^ 16'ha5c3;
        dq_o = rd ? last : ~last;
    end
endmodule : flash_dev_model

// ===== sim/testbench.sv
// self-checking bench for the flash mode and protection host controller
// assumes the behavioural flash model and a four-sector scan
`timescale 1ns/10ps
module testbench;
    import flash_host_pkg::*;
    localparam logic [7:0] MFR = 8'h3c; // arbitrary value
    localparam logic [7:0] DEV = 8'h5e; // arbitrary value
    logic              clk_i = 0;
    logic              resetn_i = 0;
    logic              valid = 0;
    logic              lock = 0;
    logic [3:0]        op = 0;
    logic [ADDR_W-1:0] a = 0, r, addr_o;
    logic [DATA_W-1:0] d = 0, dq_i, dq_o, rsp_data;
    logic [127:0]      prot = 0;
    logic              ready, rsp_valid, rsp_err, permit, dq_oe;
    logic              ce_n, oe_n, we_n, hv_id, hv_clr;
    logic [17:0]       exp_q[$];
    logic [17:0]       e;
    int                n_mismatch = 0;
    int                n_tests = 0;
    always #50 clk_i = ~clk_i;
    flash_mode_protect_host #(.SECT_STEPS(4)) u_dut (
        .clk_i(clk_i), .resetn_i(resetn_i), .cmd_valid_i(valid),
        .cmd_ready_o(ready), .cmd_op_i(op), .cmd_addr_i(a),
        .cmd_data_i(d), .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data),
        .rsp_err_o(rsp_err), .unprot_permit_o(permit),
        .supply_lockout_level_i(lock), .dq_i(dq_i), .dq_o(dq_o),
        .dq_oe_o(dq_oe), .addr_o(addr_o), .ce_n_o(ce_n), .oe_n_o(oe_n),
        .we_n_o(we_n), .id_select_hv_o(hv_id), .clear_pin_hv_o(hv_clr));
    flash_dev_model #(.MFR(MFR), .DEV(DEV)) u_flash (
        .addr_i(addr_o), .dq_i(dq_o), .ce_n_i(ce_n), .oe_n_i(oe_n),
        .we_n_i(we_n), .id_hv_i(hv_id), .prot_i(prot), .dq_o(dq_i));
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        n_tests++;
        if (seen !== want) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask : check
    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : stop_test
    // expectation: {compare data, error, data}
    task automatic run(input logic [3:0] o, input logic [ADDR_W-1:0] ad,
                       input logic [15:0] dd, input logic [17:0] ex);
        exp_q.push_back(ex);
        @(negedge clk_i);
        while (ready !== 1'b1) @(negedge clk_i);
        {op, a, d, valid} = {o, ad, dd, 1'b1};
        @(negedge clk_i) valid = 0;
        for (int n = 0; n < 2000 && exp_q.size() != 0; n++) @(negedge clk_i);
    endtask : run
    function automatic logic [17:0] arr(input logic [ADDR_W-1:0] x);
        return {2'b10, x[15:0] ^ 16'ha5c3};
    endfunction : arr
    always @(negedge clk_i) begin
        if (rsp_valid === 1'b1 && exp_q.size() != 0) begin
            e = exp_q.pop_front();
            check({15'h0, rsp_err}, {15'h0, e[16]});
            if (e[17]) check(rsp_data, e[15:0]);
        end
    end
    initial begin
        #2000000;
        n_mismatch++;
        stop_test();
    end
    initial begin
        void'($urandom(97852));
        repeat (20) @(negedge clk_i);
        resetn_i = 1;
        repeat (4) @(negedge clk_i);
        for (int i = 0; i < 4; i++) begin
            r = ADDR_W'($urandom);
            run(OP_READ, r, 0, arr(r));
        end
        run(OP_ID_CMD, 19'h00000, 0, {2'b10, 8'h00, MFR});
        run(OP_ID_CMD, 19'h00001, 0, {2'b10, 8'h00, DEV});
        run(OP_READ, 19'h00001, 0, arr(19'h00001));
        run(OP_ID_HV, 19'h00001, 0, {2'b10, 8'h00, DEV});
        run(OP_PROT_CHECK, 19'h03123, 0, 18'h20000);
        prot[3] = 1'b1;
        run(OP_PROT_CHECK, 19'h03123, 0, 18'h20001);
        run(OP_UNPROT_PREP, 0, 0, 18'h10000);
        check({15'h0, permit}, 16'h0000);
        prot[3:0] = 4'hf;
        run(OP_UNPROT_PREP, 0, 0, 18'h00000);
        check({15'h0, permit}, 16'h0001);
        run(OP_POLL, 19'h00020, 0, arr(19'h00020));
        for (int i = 0; i < 2; i++) begin
            run(OP_TEMP_UNPROT, 0, 16'(i), 18'h00000);
            check({15'h0, hv_clr}, 16'(i));
        end
        lock = 1;
        repeat (4) @(negedge clk_i);
        run(OP_WRITE, ADR_UNLOCK1, 16'(CMD_UNLOCK1), 18'h10000);
        run(OP_RESET, 0, 16'(CMD_RESET), 18'h10000);
        lock = 0;
        repeat (4) @(negedge clk_i);
        run(OP_WRITE, 19'h00000, 16'h0000, 18'h00000);
        run(OP_RESET, 19'h12345, 16'(CMD_RESET), 18'h00000);
        check(16'(exp_q.size()), 16'h0000);
        stop_test();
    end
endmodule : testbench
